// ===== design/config_decode.sv
// Decode of the base and extended configuration registers loaded by command.
`timescale 1ns/1ns

// Operation
// - Test-mode bit set: keep fields, enter test
// - Loop reset bit self-clears after issuing reset
// - Auto precharge starts delay-field clocks after burst
// - Exit select 0: fast exit, loop runs
// - Exit select 1: slow exit, loop frozen
// - Exit select ignored in precharge power-down
// - Read column delay 3 to 7 clocks
// - First data at edge n plus delay
// - Posted extra delay holds READ internally
// - Extended register holds until reprogrammed
// - Loop enable set while extended bit zero is clear
// - Self refresh disables, exit re-enables and resets loop
// - Drive strength bit selects full or reduced
// - Complement disable bit makes strobe single-ended
// - Redundant strobe on x8, complement gated
// - Output disable bit turns off data/strobe buffers
// - Burst length four/eight and ordering bit
// - Read latency posted plus column, write one less
module config_decode
    import config_decode_pkg::*;
#(
    parameter int BYTE_WIDTH = 8
)
(
    input  wire logic                clk,
    input  wire logic                resetn,
    input  wire logic                load_config_command,
    input  wire logic [BANK_W-1:0]   bank_sel,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic                read_cmd,
    input  wire logic                write_burst_done,
    input  wire logic                active_pd,
    input  wire logic                precharge_pd,
    input  wire logic                self_refresh,
    output timing_cfg_t              timing_cfg,
    output io_cfg_t                  io_cfg,
    output logic                     read_internal,
    output logic                     read_data_start,
    output logic                     auto_precharge_start,
    output logic                     config_illegal
);

    // Only the three documented data widths have a strobe arrangement defined.
    if (BYTE_WIDTH != 4 && BYTE_WIDTH != 8 && BYTE_WIDTH != 16)
    begin : g_bad_width
        $error("config_decode: BYTE_WIDTH must be 4, 8 or 16.");
    end

    // ----------------------------------------------------------------
    // Command inputs synchronised
    // ----------------------------------------------------------------
    // Command pins come from the controller's clock; two stages each.
    localparam int SYN_W = 1 + BANK_W + ADDR_W + 6;
    logic [SYN_W-1:0] sync1_ff;
    logic [SYN_W-1:0] sync2_ff;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= {load_config_command, bank_sel, addr, read_cmd, write_burst_done,
                         active_pd, precharge_pd, self_refresh, 1'b0};
            sync2_ff <= sync1_ff;
        end
    end

    wire              s_load   = sync2_ff[SYN_W-1];
    wire [BANK_W-1:0] s_bank   = sync2_ff[SYN_W-2 -: BANK_W];
    wire [ADDR_W-1:0] s_addr   = sync2_ff[ADDR_W+5:6];
    wire              s_read   = sync2_ff[5];
    wire              s_wdone  = sync2_ff[4];
    wire              s_apd    = sync2_ff[3];
    wire              s_ppd    = sync2_ff[2];
    wire              s_sref   = sync2_ff[1];

    // ----------------------------------------------------------------
    // Register load
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] base_config_register_ff;
    logic [ADDR_W-1:0] extended_config_register_ff;
    logic              test_ff;
    logic              sref_d_ff;

    wire load_base = s_load && (s_bank == SEL_BASE);
    wire load_ext  = s_load && (s_bank == SEL_EXT);
    wire test_req  = s_addr[TEST_BIT];
    wire sref_exit = sref_d_ff && !s_sref;

    // A test-mode load writes nothing else into the base register.
    wire [ADDR_W-1:0] nxt_base =
        (load_base && !test_req) ? s_addr :
        {base_config_register_ff[ADDR_W-1:LRST_BIT+1], 1'b0,
         base_config_register_ff[LRST_BIT-1:0]};
    wire [ADDR_W-1:0] nxt_ext = load_ext ? s_addr : extended_config_register_ff;

    wire loop_reset_req = (load_base && !test_req && s_addr[LRST_BIT]) || sref_exit;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            base_config_register_ff     <= BASE_RST;
            extended_config_register_ff <= EXT_RST;
            test_ff                     <= 1'b0;
            sref_d_ff                   <= 1'b0;
        end
        else
        begin
            base_config_register_ff     <= nxt_base;
            extended_config_register_ff <= nxt_ext;
            test_ff                     <= load_base ? test_req : test_ff;
            sref_d_ff                   <= s_sref;
        end
    end

    // ----------------------------------------------------------------
    // Field decode
    // ----------------------------------------------------------------
    wire [2:0] rcd_code = base_config_register_ff[RCD_LSB +: 3];
    wire [2:0] apd_code = base_config_register_ff[APD_LSB +: 3];
    wire [2:0] ped_code = extended_config_register_ff[PED_LSB +: 3];
    wire [2:0] bl_code  = base_config_register_ff[BL_LSB +: 3];

    wire rcd_bad = (rcd_code < RCD_MIN) || (rcd_code > RCD_MAX);
    wire apd_bad = (apd_code < APD_MIN) || (apd_code > APD_MAX);
    wire ped_bad = ped_code > PED_MAX;
    wire bl_bad  = (bl_code != BL4_CODE) && (bl_code != BL8_CODE);
    wire illegal = rcd_bad || apd_bad || ped_bad || bl_bad;

    // Recovery code k means k+1 clocks, so codes 1..7 give 2..8.
    wire [3:0] apd_clocks = 4'(apd_code) + 4'h1;
    wire [3:0] rd_lat     = 4'(rcd_code) + 4'(ped_code);
    wire [3:0] wr_lat     = (rd_lat == 4'h0) ? 4'h0 : rd_lat - 4'h1;
    wire [3:0] blen       = (bl_code == BL8_CODE) ? 4'h8 : 4'h4;

    // ----------------------------------------------------------------
    // Power-down and loop state
    // ----------------------------------------------------------------
    pd_state_t pd_ff;
    pd_state_t nxt_pd;

    assign nxt_pd = s_sref ? PD_SELF :
                    s_ppd  ? PD_PRECHARGE :
                    s_apd  ? PD_ACTIVE : PD_NONE;

    wire loop_on = extended_config_register_ff[LEN_BIT] == 1'b0 && pd_ff != PD_SELF;
    // Only active power-down consults the exit select.
    wire frozen  = pd_ff == PD_ACTIVE && base_config_register_ff[PDX_BIT];

    logic [7:0] lock_ff;
    wire  [7:0] nxt_lock = (loop_reset_req || !loop_on) ? LOCK_CNT :
                           (lock_ff != 8'h0) ? lock_ff - 8'h1 : lock_ff;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pd_ff   <= PD_NONE;
            lock_ff <= LOCK_CNT;
        end
        else
        begin
            pd_ff   <= nxt_pd;
            lock_ff <= nxt_lock;
        end
    end

    // ----------------------------------------------------------------
    // Read and auto precharge timing
    // ----------------------------------------------------------------
    // One-hot shift lines; the tap picks the programmed delay, so a
    // change of configuration mid-flight is the controller's hazard.
    logic [15:0] post_ff;
    logic [15:0] cas_ff;
    logic [15:0] wr_ff;

    wire [15:0] nxt_post = {post_ff[14:0], s_read};
    wire        rd_int   = (ped_code == 3'h0) ? s_read : post_ff[ped_code - 3'h1];
    wire [15:0] nxt_cas  = {cas_ff[14:0], rd_int};
    wire        rd_data  = cas_ff[rcd_code - 3'h1];
    wire [15:0] nxt_wr   = {wr_ff[14:0], s_wdone};
    wire        ap_go    = wr_ff[apd_clocks - 4'h1];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            post_ff <= '0;
            cas_ff  <= '0;
            wr_ff   <= '0;
        end
        else
        begin
            post_ff <= nxt_post;
            cas_ff  <= nxt_cas;
            wr_ff   <= nxt_wr;
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    wire x8          = BYTE_WIDTH == 8;
    wire cmp_en      = !extended_config_register_ff[SCD_BIT];
    wire rrs_en      = x8 && extended_config_register_ff[RRS_BIT];

    timing_cfg_t nxt_timing;
    io_cfg_t     nxt_io;

    assign nxt_timing.test_mode            = test_ff;
    assign nxt_timing.slow_exit            = base_config_register_ff[PDX_BIT];
    assign nxt_timing.read_column_delay    = rcd_code;
    assign nxt_timing.posted_extra_delay   = ped_code;
    assign nxt_timing.read_latency         = rd_lat;
    assign nxt_timing.write_latency        = wr_lat;
    assign nxt_timing.auto_precharge_delay = apd_clocks;
    assign nxt_timing.burst_len            = blen;
    assign nxt_timing.interleaved          = base_config_register_ff[BO_BIT];

    assign nxt_io.loop_enable      = loop_on;
    assign nxt_io.loop_reset       = loop_reset_req;
    assign nxt_io.loop_frozen      = frozen;
    assign nxt_io.loop_locked      = loop_on && lock_ff == 8'h0;
    assign nxt_io.reduced_drive    = extended_config_register_ff[DRV_BIT];
    assign nxt_io.strobe_cmp_en    = cmp_en;
    assign nxt_io.rd_strobe_en     = rrs_en;
    assign nxt_io.rd_strobe_cmp_en = rrs_en && cmp_en;
    assign nxt_io.outputs_en       = !extended_config_register_ff[ODIS_BIT];

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timing_cfg           <= '0;
            io_cfg               <= '0;
            read_internal        <= 1'b0;
            read_data_start      <= 1'b0;
            auto_precharge_start <= 1'b0;
            config_illegal       <= 1'b0;
        end
        else
        begin
            timing_cfg           <= nxt_timing;
            io_cfg               <= nxt_io;
            read_internal        <= rd_int;
            read_data_start      <= rd_data;
            auto_precharge_start <= ap_go;
            config_illegal       <= illegal;
        end
    end

endmodule

// ===== common/config_decode_pkg.sv
// Package with field layouts, codes and timing for the configuration decode block.
package config_decode_pkg;

    // ----------------------------------------------------------------
    // Command bus layout
    // ----------------------------------------------------------------
    localparam int ADDR_W            = 13;
    localparam int BANK_W            = 2;
    localparam logic [1:0] SEL_BASE  = 2'h0;
    localparam logic [1:0] SEL_EXT   = 2'h1;

    // ----------------------------------------------------------------
    // Base register fields
    // ----------------------------------------------------------------
    localparam int BL_LSB            = 0;
    localparam int BO_BIT            = 3;
    localparam int RCD_LSB           = 4;
    localparam int TEST_BIT          = 7;
    localparam int LRST_BIT          = 8;
    localparam int APD_LSB           = 9;
    localparam int PDX_BIT           = 12;
    localparam logic [2:0] BL4_CODE  = 3'h2;
    localparam logic [2:0] BL8_CODE  = 3'h3;
    localparam logic [2:0] RCD_MIN   = 3'h3;
    localparam logic [2:0] RCD_MAX   = 3'h7;
    localparam logic [2:0] APD_MIN   = 3'h1;
    localparam logic [2:0] APD_MAX   = 3'h7;

    // ----------------------------------------------------------------
    // Extended register fields
    // ----------------------------------------------------------------
    localparam int LEN_BIT           = 0;
    localparam int DRV_BIT           = 1;
    localparam int PED_LSB           = 3;
    localparam int SCD_BIT           = 10;
    localparam int RRS_BIT           = 11;
    localparam int ODIS_BIT          = 12;
    localparam logic [2:0] PED_MAX   = 3'h6;

    // ----------------------------------------------------------------
    // Reset values and timing
    // ----------------------------------------------------------------
    localparam logic [12:0] BASE_RST = 13'h0632;
    localparam logic [12:0] EXT_RST  = 13'h0000;
    localparam int LOCK_CYCLES       = 200;
    localparam logic [7:0] LOCK_CNT  = 8'(LOCK_CYCLES);

    typedef struct packed {
        logic       test_mode;
        logic       slow_exit;
        logic [2:0] read_column_delay;
        logic [2:0] posted_extra_delay;
        logic [3:0] read_latency;
        logic [3:0] write_latency;
        logic [3:0] auto_precharge_delay;
        logic [3:0] burst_len;
        logic       interleaved;
    } timing_cfg_t;

    typedef struct packed {
        logic loop_enable;
        logic loop_reset;
        logic loop_frozen;
        logic loop_locked;
        logic reduced_drive;
        logic strobe_cmp_en;
        logic rd_strobe_en;
        logic rd_strobe_cmp_en;
        logic outputs_en;
    } io_cfg_t;

    typedef enum logic [1:0] {
        PD_NONE,
        PD_ACTIVE,
        PD_PRECHARGE,
        PD_SELF
    } pd_state_t;

endpackage

// ===== tb/config_decode_chk.sv
// Concurrent checks on the ports of the configuration decode block.
`timescale 1ns/1ns
module config_decode_chk
    import config_decode_pkg::*;
#(
    parameter int BYTE_WIDTH = 8
)
(
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic              load_config_command,
    input wire logic [BANK_W-1:0] bank_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic              read_cmd,
    input wire logic              write_burst_done,
    input wire logic              active_pd,
    input wire logic              precharge_pd,
    input wire logic              self_refresh,
    input wire timing_cfg_t       timing_cfg,
    input wire io_cfg_t           io_cfg,
    input wire logic              read_internal,
    input wire logic              read_data_start,
    input wire logic              auto_precharge_start,
    input wire logic              config_illegal
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    wire         load_base = load_config_command && bank_sel == SEL_BASE;
    wire         base_ld   = load_base && !addr[TEST_BIT];
    wire         ext_ld    = load_config_command && bank_sel == SEL_EXT;
    logic [31:0] hist_ff;
    // Strobe history lets latencies chosen by the registers be checked without fixed delays.
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            hist_ff <= 32'h0;
        else
            hist_ff <= {hist_ff[30:16], write_burst_done, hist_ff[14:0], read_cmd};
    cl_load_a: assert property (base_ld |-> ##4 timing_cfg.read_column_delay == $past(addr[6:4], 4))
        else $error("column delay not loaded");
    test_hold_a: assert property (load_base && addr[TEST_BIT] |-> ##4 timing_cfg.test_mode
        && $stable(timing_cfg.auto_precharge_delay)) else $error("test load changed fields");
    loop_pulse_a: assert property (base_ld && addr[LRST_BIT] |-> ##3 io_cfg.loop_reset ##1 !io_cfg.loop_reset)
        else $error("loop reset not one pulse");
    ext_io_a: assert property (
        ext_ld |-> ##4 {io_cfg.reduced_drive, io_cfg.strobe_cmp_en, io_cfg.rd_strobe_en, io_cfg.outputs_en}
        == $past({addr[DRV_BIT], !addr[SCD_BIT], addr[RRS_BIT] && BYTE_WIDTH == 8, !addr[ODIS_BIT]}, 4))
        else $error("output bits not loaded");
    loop_en_a: assert property (ext_ld && !self_refresh |-> ##4 io_cfg.loop_enable != $past(addr[LEN_BIT], 4))
        else $error("loop enable wrong");
    self_ref_a: assert property ($fell(self_refresh) |-> ##[3:5] io_cfg.loop_reset)
        else $error("no loop reset after self refresh");
    frozen_a: assert property (
        $stable({active_pd, precharge_pd, self_refresh, timing_cfg.slow_exit}) [*4] |-> io_cfg.loop_frozen
        == (active_pd && !precharge_pd && !self_refresh && timing_cfg.slow_exit)) else $error("loop freeze wrong");
    rd_lat_a: assert property (read_data_start == hist_ff[2 + timing_cfg.read_latency])
        else $error("read data start misplaced");
    rd_int_a: assert property (read_internal == hist_ff[2 + timing_cfg.posted_extra_delay])
        else $error("internal read misplaced");
    ap_lat_a: assert property (auto_precharge_start == hist_ff[18 + timing_cfg.auto_precharge_delay])
        else $error("precharge start misplaced");
    illegal_a: assert property (base_ld && addr[6:4] < RCD_MIN |-> ##4 config_illegal)
        else $error("reserved delay not flagged");
    lat_sum_a: assert property (timing_cfg.read_latency != 4'h0 |->
        timing_cfg.write_latency == timing_cfg.read_latency - 4'h1) else $error("write latency wrong");
    cover property (read_data_start);
    cover property (auto_precharge_start);
    cover property (io_cfg.loop_frozen);
endmodule
bind config_decode config_decode_chk #(.BYTE_WIDTH(BYTE_WIDTH)) u_chk (.*);

// ===== tb/mem_ctrl_model.sv
// Behavioural memory controller issuing configuration loads and access strobes.
`timescale 1ns/1ns
module mem_ctrl_model
    import config_decode_pkg::*;
#(
    parameter int CFG_WAIT = 2
)
(
    input  wire logic         clk,
    output logic              load_config_command,
    output logic [BANK_W-1:0] bank_sel,
    output logic [ADDR_W-1:0] addr,
    output logic              read_cmd,
    output logic              write_burst_done
);
    localparam int CLK_NS = 50;
    int cyc      = 0;
    int reset_at = 0;
    initial
    begin
        load_config_command = 1'b0;
        bank_sel            = SEL_BASE;
        addr                = 13'h0000;
        read_cmd            = 1'b0;
        write_burst_done    = 1'b0;
    end
    always @(posedge clk) cyc <= cyc + 1;
    // Recovery is clamped into the legal clock range before it is encoded.
    function automatic logic [12:0] base_word(input logic [2:0] cl, input int wr, input logic lrst, input logic slow);
        int w;
        w = (wr < 2) ? 2 : (wr > 8) ? 8 : wr;
        return {slow, 3'(w - 1), lrst, 1'b0, cl, 1'b0, BL4_CODE};
    endfunction
    // Recovery time in nanoseconds becomes whole clocks, a fraction rounding up.
    function automatic int rec_clocks(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction
    task automatic load(input logic [BANK_W-1:0] sel, input logic [ADDR_W-1:0] val);
        @(posedge clk);
        load_config_command <= 1'b1;
        bank_sel            <= sel;
        addr                <= val;
        if (sel == SEL_BASE && val[LRST_BIT])
            reset_at = cyc;
        @(posedge clk);
        load_config_command <= 1'b0;
        addr                <= ~val;
        repeat (CFG_WAIT) @(posedge clk);
    endtask
    // Reads wait out the lock time, since early data would break output timing.
    task automatic pulse(input logic rd, output int at);
        if (rd)
            while (cyc - reset_at < LOCK_CYCLES) @(posedge clk);
        @(posedge clk);
        at = cyc;
        read_cmd         <= rd;
        write_burst_done <= !rd;
        @(posedge clk);
        read_cmd         <= 1'b0;
        write_burst_done <= 1'b0;
    endtask
endmodule

// ===== tb/test_sdram_mode_register_decode.sv
// Self-checking bench for the configuration decode block.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin cmp_count++; if ((s) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module test_sdram_mode_register_decode
    import config_decode_pkg::*;
;
    logic              clk, resetn, active_pd, precharge_pd, self_refresh;
    logic              load_config_command, read_cmd, write_burst_done;
    logic [BANK_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr;
    timing_cfg_t       timing_cfg;
    io_cfg_t           io_cfg;
    logic              read_internal, read_data_start, auto_precharge_start, config_illegal;
    logic [2:0]        al;
    logic [12:0]       e;
    int                failures = 0, cmp_count = 0, cyc = 0, seed = 29, at, wr, q_rd[$], q_ap[$];

    config_decode #(.BYTE_WIDTH(8)) dut (.*);
    mem_ctrl_model u_ctrl (.*);

    task automatic results();
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic take(ref int q[$], input string nm);
        int x;
        x = (q.size() > 0) ? q.pop_front() : -1;
        `CHK(nm, x, cyc)
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Results are matched against the oldest expected cycle, so a lost or extra pulse shows.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (read_data_start)
            take(q_rd, "read_start");
        if (auto_precharge_start)
            take(q_ap, "precharge_start");
        if (cyc == 5000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        {resetn, active_pd, precharge_pd, self_refresh} = 4'h0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("io_reset", 9'h109, io_cfg)
        `CHK("base_reset", {3'h3, 4'h4}, {timing_cfg.read_column_delay, timing_cfg.burst_len})
        for (int cl = 3; cl <= 7; cl++)
        begin
            al = 3'($unsigned($random(seed)) % 7);
            wr = u_ctrl.rec_clocks(51 + $unsigned($random(seed)) % 350);
            e = (13'($random(seed)) & 13'h1c02) | {7'h00, al, 3'h0};
            u_ctrl.load(SEL_EXT, e);
            u_ctrl.load(SEL_BASE, u_ctrl.base_word(3'(cl), wr, cl == 3, 1'b0));
            repeat (3) @(posedge clk);
            `CHK("latency", {4'(al + cl), 4'(al + cl - 1), 4'(wr)}, {timing_cfg.read_latency, timing_cfg.write_latency, timing_cfg.auto_precharge_delay})
            `CHK("io", {e[1], !e[10], e[11], e[11] & !e[10], !e[12]}, {io_cfg.reduced_drive, io_cfg.strobe_cmp_en, io_cfg.rd_strobe_en, io_cfg.rd_strobe_cmp_en, io_cfg.outputs_en})
            u_ctrl.pulse(1'b1, at);
            q_rd.push_back(at + 4 + al + cl);
            u_ctrl.pulse(1'b0, at);
            q_ap.push_back(at + 4 + wr);
            repeat (20) @(posedge clk);
        end
        `CHK("pending", 0, q_rd.size() + q_ap.size())
        `CHK("locked", 1'b1, io_cfg.loop_locked)
        u_ctrl.load(SEL_BASE, u_ctrl.base_word(3'h5, 4, 1'b0, 1'b0) | 13'h0080);
        repeat (3) @(posedge clk);
        `CHK("test_mode", {1'b1, 3'h7}, {timing_cfg.test_mode, timing_cfg.read_column_delay})
        u_ctrl.load(SEL_BASE, u_ctrl.base_word(3'h2, 4, 1'b0, 1'b0));
        repeat (3) @(posedge clk);
        `CHK("illegal", 2'b01, {timing_cfg.test_mode, config_illegal})
        for (int s = 0; s < 2; s++)
            for (int p = 0; p < 2; p++)
            begin
                u_ctrl.load(SEL_BASE, u_ctrl.base_word(3'h4, 3, 1'b0, 1'(s)));
                active_pd <= 1'b1;
                precharge_pd <= 1'(p);
                repeat (6) @(posedge clk);
                `CHK("frozen", 1'(s & ~p), io_cfg.loop_frozen)
            end
        {active_pd, precharge_pd, self_refresh} <= 3'h1;
        repeat (6) @(posedge clk);
        `CHK("self_refresh", 2'b00, {io_cfg.loop_enable, io_cfg.loop_locked})
        self_refresh <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK("refresh_exit", 1'b1, io_cfg.loop_enable)
        u_ctrl.load(SEL_EXT, 13'h0001);
        repeat (4) @(posedge clk);
        `CHK("loop_off", 2'b00, {io_cfg.loop_enable, io_cfg.loop_locked})
        results();
    end
endmodule
